//--- rtl/wir_defs.svh
`ifndef WIR_DEFS_SVH
`define WIR_DEFS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define WIR_CLK_KHZ 40000
`define WIR_RST_HOLD_US 18000
`define WIR_RST_HOLD_CYC ((`WIR_RST_HOLD_US * `WIR_CLK_KHZ) / 1000)
`define WIR_RST_CNT_W 20

// ****************************************************************
// addresses and reset values
// ****************************************************************
`define WIR_IRQ_VECTOR 16'h0006
`define WIR_VEC_RST 16'h0000
`define WIR_SRC_W 4
`define WIR_SRC_EXT 0
`define WIR_SRC_TMR 1
`define WIR_SRC_PIN 2
`define WIR_SRC_SER 3
`define WIR_TFLAG_POR 1'b1
`define WIR_PFLAG_POR 1'b1

`endif

//--- rtl/wir_pin_reset_det.sv
`timescale 1ns/10ps
`include "wir_defs.svh"

module wir_pin_reset_det (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // reset pin, active low
  input wire logic reset_pin_n_in,
  // detection
  output logic low_start_out,
  output logic held_out
);

  logic pin_q_r;

  // previous pin level, idle high
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q_r <= 1'b1;
    end else begin
      pin_q_r <= reset_pin_n_in;
    end
  end

  // high-to-low edge starts the reset; low level keeps it held
  assign low_start_out = pin_q_r & ~reset_pin_n_in;
  assign held_out = ~reset_pin_n_in;

endmodule

//--- rtl/wir_pkg.sv
package wir_pkg;

  // operating mode of the core
  typedef enum logic [1:0] {
    WIR_MODE_NORMAL = 2'h0,
    WIR_MODE_GREEN = 2'h1,
    WIR_MODE_IDLE = 2'h3,
    WIR_MODE_SLEEP = 2'h2
  } wir_mode_e;

  // sequencer states, gray along run -> low power -> run
  typedef enum logic [1:0] {
    WIR_ST_RUN = 2'h0,
    WIR_ST_LP = 2'h1,
    WIR_ST_RST = 2'h3
  } wir_state_e;

  // what an event asks the core to do
  typedef enum logic [1:0] {
    WIR_ACT_NONE = 2'h0,
    WIR_ACT_NEXT = 2'h1,
    WIR_ACT_VEC = 2'h2
  } wir_act_e;

endpackage

//--- rtl/wir_status_flags.sv
`timescale 1ns/10ps
`include "wir_defs.svh"

module wir_status_flags (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // events
  input wire logic lvr_evt_in,
  input wire logic pin_rst_evt_in,
  input wire logic wdt_rst_evt_in,
  input wire logic in_sleep_in,
  input wire logic sleep_wake_evt_in,
  input wire logic sleep_op_in,
  input wire logic wdt_clear_op_in,
  // flags
  output logic timeout_flag_out,
  output logic power_down_flag_out
);

  // time-out flag; reset events outrank instructions
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timeout_flag_out <= `WIR_TFLAG_POR;
    end else if (lvr_evt_in) begin
      timeout_flag_out <= `WIR_TFLAG_POR;
    end else if (wdt_rst_evt_in) begin
      timeout_flag_out <= 1'b0;
    end else if (pin_rst_evt_in) begin
      if (in_sleep_in) begin
        timeout_flag_out <= 1'b1;
      end
    end else if (sleep_wake_evt_in | sleep_op_in | wdt_clear_op_in) begin
      timeout_flag_out <= 1'b1;
    end
  end

  // power-down flag; operating resets keep it
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_down_flag_out <= `WIR_PFLAG_POR;
    end else if (lvr_evt_in) begin
      power_down_flag_out <= `WIR_PFLAG_POR;
    end else if (wdt_rst_evt_in | pin_rst_evt_in) begin
      if (in_sleep_in) begin
        power_down_flag_out <= 1'b0;
      end
    end else if (sleep_wake_evt_in | sleep_op_in) begin
      power_down_flag_out <= 1'b0;
    end else if (wdt_clear_op_in) begin
      power_down_flag_out <= 1'b1;
    end
  end

endmodule

//--- rtl/wir_wake_ctrl.sv
`timescale 1ns/10ps
`include "wir_defs.svh"

module wir_wake_ctrl #(
  parameter int RST_HOLD_CYC = `WIR_RST_HOLD_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,

  // instructions from the core, one-cycle pulses
  input wire logic sleep_op_in,
  input wire logic idle_op_in,
  input wire logic global_irq_enable_op_in,
  input wire logic global_irq_disable_op_in,
  input wire logic watchdog_clear_op_in,

  // running mode select: 1 green, 0 normal
  input wire logic green_sel_in,

  // external pin source
  input wire logic ext_pin_wake_enable_in,
  input wire logic ext_pin_irq_enable_in,
  input wire logic ext_irq_pins_evt_in,

  // timer overflow source
  input wire logic timer_overflow_irq_enable_in,
  input wire logic timer_counter_mode_in,
  input wire logic timer_overflow_evt_in,

  // port change source
  input wire logic pin_change_wake_enable_in,
  input wire logic pin_change_irq_enable_in,
  input wire logic pin_change_evt_in,

  // serial bus source
  input wire logic serial_slave_wake_enable_in,
  input wire logic serial_bus_irq_enable_in,
  input wire logic serial_slave_mode_in,
  input wire logic serial_rx_evt_in,

  // reset sources
  input wire logic reset_pin_n_in,
  input wire logic watchdog_timer_enable_in,
  input wire logic watchdog_timer_timeout_in,
  input wire logic low_voltage_reset_enable_in,
  input wire logic low_voltage_reset_in,

  // sequencing to the core
  output logic core_reset_out,
  output logic core_halt_out,
  output logic [1:0] mode_out,
  output logic wake_out,
  output logic resume_next_out,
  output logic irq_vector_req_out,
  output logic [15:0] vector_addr_out,
  output logic [`WIR_SRC_W-1:0] wake_src_out,
  output logic global_irq_enabled_out,
  output logic watchdog_clear_out,
  output logic serial_unusable_out,

  // status bits
  output logic timeout_flag_out,
  output logic power_down_flag_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  wir_pkg::wir_state_e state_r;
  wir_pkg::wir_state_e state_nxt;
  wir_pkg::wir_mode_e mode_r;
  wir_pkg::wir_mode_e mode_nxt;
  wir_pkg::wir_mode_e run_mode;
  wir_pkg::wir_act_e act_src [`WIR_SRC_W];
  wir_pkg::wir_act_e act_best;
  logic [`WIR_SRC_W-1:0] evt_vec;
  logic [`WIR_SRC_W-1:0] hit_vec;
  logic [`WIR_RST_CNT_W-1:0] cnt_r;
  logic cnt_done;
  logic gie_r;
  logic lp;
  logic run;
  logic is_sleep;
  logic is_idle;
  logic is_norm;
  logic pin_low_start;
  logic pin_held;
  logic wdt_trig;
  logic lvr_trig;
  logic rst_trig;
  logic sleep_go;
  logic idle_go;
  logic wake_go;
  logic sleep_wake;

  // ****************************************************************
  // decoding
  // ****************************************************************

  // action of one source: in low power it must be allowed to wake,
  // and it only vectors where the mode lets it; running, it follows gie
  function automatic wir_pkg::wir_act_e wir_act_f(
    input logic in_lp,
    input logic wake_ok,
    input logic vec_ok,
    input logic run_ok,
    input logic gie
  );
    wir_pkg::wir_act_e res;
    res = wir_pkg::WIR_ACT_NONE;
    if (in_lp) begin
      if (wake_ok) begin
        res = (vec_ok && gie) ? wir_pkg::WIR_ACT_VEC
                              : wir_pkg::WIR_ACT_NEXT;
      end
    end else if (run_ok) begin
      res = gie ? wir_pkg::WIR_ACT_VEC : wir_pkg::WIR_ACT_NEXT;
    end
    return res;
  endfunction

  // mode qualifiers
  assign lp = (state_r == wir_pkg::WIR_ST_LP);
  assign run = (state_r == wir_pkg::WIR_ST_RUN);
  assign is_sleep = (mode_r == wir_pkg::WIR_MODE_SLEEP);
  assign is_idle = (mode_r == wir_pkg::WIR_MODE_IDLE);
  assign is_norm = (mode_r == wir_pkg::WIR_MODE_NORMAL);
  assign run_mode = green_sel_in ? wir_pkg::WIR_MODE_GREEN
                                 : wir_pkg::WIR_MODE_NORMAL;

  // ****************************************************************
  // reset sources
  // ****************************************************************

  // reset pin edge and level
  wir_pin_reset_det u_pin_det (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .reset_pin_n_in(reset_pin_n_in),
    .low_start_out(pin_low_start),
    .held_out(pin_held)
  );

  // watchdog acts in every mode when enabled; low voltage likewise
  assign wdt_trig = watchdog_timer_enable_in & watchdog_timer_timeout_in;
  assign lvr_trig = low_voltage_reset_enable_in & low_voltage_reset_in;
  assign rst_trig = pin_low_start | wdt_trig | lvr_trig;

  // ****************************************************************
  // wake and interrupt sources
  // ****************************************************************

  // events sorted into a vector, indexed by source
  assign evt_vec[`WIR_SRC_EXT] = ext_irq_pins_evt_in;
  assign evt_vec[`WIR_SRC_TMR] = timer_overflow_evt_in;
  assign evt_vec[`WIR_SRC_PIN] = pin_change_evt_in;
  assign evt_vec[`WIR_SRC_SER] = serial_rx_evt_in;

  // per-source action tables
  always_comb begin
    // external pins need their irq enable everywhere; idle never vectors
    act_src[`WIR_SRC_EXT] = wir_act_f(lp,
      ext_pin_wake_enable_in & ext_pin_irq_enable_in,
      is_sleep & ext_pin_irq_enable_in,
      ext_pin_irq_enable_in, gie_r);
    // sleep wake only when the timer counts external edges
    act_src[`WIR_SRC_TMR] = wir_act_f(lp,
      timer_overflow_irq_enable_in & (is_idle | timer_counter_mode_in),
      is_sleep & timer_overflow_irq_enable_in,
      timer_overflow_irq_enable_in, gie_r);
    // port change wakes on its wake enable alone
    act_src[`WIR_SRC_PIN] = wir_act_f(lp,
      pin_change_wake_enable_in,
      pin_change_irq_enable_in,
      pin_change_irq_enable_in, gie_r);
    // serial receive wakes only as a slave; running, it interrupts only in normal
    act_src[`WIR_SRC_SER] = wir_act_f(lp,
      serial_slave_wake_enable_in & serial_slave_mode_in,
      serial_bus_irq_enable_in,
      serial_bus_irq_enable_in & is_norm, gie_r);
  end

  // sources that fire with a non-empty action
  genvar gi;
  generate
    for (gi = 0; gi < `WIR_SRC_W; gi = gi + 1) begin : g_hit
      assign hit_vec[gi] = evt_vec[gi] &
                           (act_src[gi] != wir_pkg::WIR_ACT_NONE);
    end
  endgenerate

  // vector outranks next when two sources fire together
  always_comb begin
    act_best = wir_pkg::WIR_ACT_NONE;
    for (int i = 0; i < `WIR_SRC_W; i++) begin
      if (hit_vec[i] && (act_src[i] == wir_pkg::WIR_ACT_VEC)) begin
        act_best = wir_pkg::WIR_ACT_VEC;
      end else if (hit_vec[i] && (act_best == wir_pkg::WIR_ACT_NONE)) begin
        act_best = wir_pkg::WIR_ACT_NEXT;
      end
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // requests qualified by state; reset always wins
  assign sleep_go = run & sleep_op_in & ~rst_trig;
  assign idle_go = run & ~sleep_op_in & idle_op_in & ~rst_trig;
  assign wake_go = lp & ~rst_trig & (act_best != wir_pkg::WIR_ACT_NONE);
  assign sleep_wake = wake_go & is_sleep;

  // hold counter reaches the reset time
  assign cnt_done = (cnt_r == RST_HOLD_CYC[`WIR_RST_CNT_W-1:0] -
                     `WIR_RST_CNT_W'(1));

  // next state and mode
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      wir_pkg::WIR_ST_RUN: begin
        if (rst_trig) begin
          state_nxt = wir_pkg::WIR_ST_RST;
        end else if (sleep_go) begin
          state_nxt = wir_pkg::WIR_ST_LP;
          mode_nxt = wir_pkg::WIR_MODE_SLEEP;
        end else if (idle_go) begin
          state_nxt = wir_pkg::WIR_ST_LP;
          mode_nxt = wir_pkg::WIR_MODE_IDLE;
        end else begin
          mode_nxt = run_mode;
        end
      end
      wir_pkg::WIR_ST_LP: begin
        if (rst_trig) begin
          state_nxt = wir_pkg::WIR_ST_RST;
        end else if (wake_go) begin
          state_nxt = wir_pkg::WIR_ST_RUN;
          mode_nxt = run_mode;
        end
      end
      wir_pkg::WIR_ST_RST: begin
        // stays until the pin is released and the hold time ran out
        if (!rst_trig && !pin_held && cnt_done) begin
          state_nxt = wir_pkg::WIR_ST_RUN;
          mode_nxt = wir_pkg::WIR_MODE_NORMAL;
        end
      end
      default: begin
        state_nxt = wir_pkg::WIR_ST_RST;
        mode_nxt = wir_pkg::WIR_MODE_NORMAL;
      end
    endcase
  end

  // state register; power-on starts inside the reset hold
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= wir_pkg::WIR_ST_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // mode register
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r <= wir_pkg::WIR_MODE_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // reset hold counter; any new trigger or a held pin restarts it
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= '0;
    end else if (state_r != wir_pkg::WIR_ST_RST) begin
      cnt_r <= '0;
    end else if (rst_trig || pin_held) begin
      cnt_r <= '0;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r + `WIR_RST_CNT_W'(1);
    end
  end

  // ****************************************************************
  // global interrupt state
  // ****************************************************************

  // cleared by any reset so a restart never vectors unasked
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gie_r <= 1'b0;
    end else if (rst_trig || (state_r == wir_pkg::WIR_ST_RST)) begin
      gie_r <= 1'b0;
    end else if (global_irq_enable_op_in) begin
      gie_r <= 1'b1;
    end else if (global_irq_disable_op_in) begin
      gie_r <= 1'b0;
    end
  end

  // ****************************************************************
  // answers to the core
  // ****************************************************************

  // one-cycle pulses for wake, continue and vector
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_out <= 1'b0;
      resume_next_out <= 1'b0;
      irq_vector_req_out <= 1'b0;
    end else begin
      wake_out <= wake_go;
      resume_next_out <= (lp | run) & ~rst_trig &
                         (act_best == wir_pkg::WIR_ACT_NEXT);
      irq_vector_req_out <= (lp | run) & ~rst_trig &
                            (act_best == wir_pkg::WIR_ACT_VEC);
    end
  end

  // fetch address for the core, held until the next decision
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vector_addr_out <= `WIR_VEC_RST;
    end else if (state_r == wir_pkg::WIR_ST_RST) begin
      vector_addr_out <= `WIR_VEC_RST;
    end else if ((lp | run) && !rst_trig &&
                 (act_best == wir_pkg::WIR_ACT_VEC)) begin
      vector_addr_out <= `WIR_IRQ_VECTOR;
    end
  end

  // which sources woke the core last
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_src_out <= '0;
    end else if (wake_go) begin
      wake_src_out <= hit_vec;
    end
  end

  // watchdog is cleared on sleep entry and by its own op, keeps counting
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watchdog_clear_out <= 1'b0;
    end else begin
      watchdog_clear_out <= sleep_go | (watchdog_clear_op_in & ~rst_trig);
    end
  end

  // plain status views
  assign core_reset_out = (state_r == wir_pkg::WIR_ST_RST);
  assign core_halt_out = lp;
  assign mode_out = mode_r;
  assign global_irq_enabled_out = gie_r;
  assign serial_unusable_out = (mode_r == wir_pkg::WIR_MODE_GREEN);

  // ****************************************************************
  // reset and wake cause flags
  // ****************************************************************

  // software reads these to tell why the core restarted
  wir_status_flags u_flags (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .lvr_evt_in(lvr_trig),
    .pin_rst_evt_in(pin_low_start),
    .wdt_rst_evt_in(wdt_trig),
    .in_sleep_in(lp & is_sleep),
    .sleep_wake_evt_in(sleep_wake),
    .sleep_op_in(sleep_go),
    .wdt_clear_op_in(watchdog_clear_op_in & run & ~rst_trig),
    .timeout_flag_out(timeout_flag_out),
    .power_down_flag_out(power_down_flag_out)
  );

endmodule

//--- verif/test_wir_wake_ctrl.sv
`timescale 1ns/10ps
module test_wir_wake_ctrl;
  // ****************
  // bench signals
  // ****************
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic reset_pin_n_in = 1'b1;
  logic watchdog_timer_enable_in = 1'b0;
  logic watchdog_timer_timeout_in = 1'b0;
  logic low_voltage_reset_enable_in = 1'b0;
  logic low_voltage_reset_in = 1'b0;
  logic [4:0] op = 5'h00; // sleep, idle, irq on, irq off, watchdog clear
  logic [3:0] ev = 4'h0; // ext pin, timer, port change, serial
  logic [9:0] en = 10'h000; // bit 9 selects green
  logic core_reset_out, core_halt_out, wake_out, resume_next_out;
  logic irq_vector_req_out, global_irq_enabled_out, watchdog_clear_out;
  logic serial_unusable_out, timeout_flag_out, power_down_flag_out;
  logic [1:0] mode_out;
  logic [3:0] wake_src_out;
  logic [15:0] vector_addr_out, pc;
  int failures = 0;
  int num_checks = 0;

  // 40 MHz core clock
  always #12.5 core_clk_in = ~core_clk_in;

  // short reset hold keeps the run brief
  wir_wake_ctrl #(.RST_HOLD_CYC(8)) i_wir_wake_ctrl (.*,
    .sleep_op_in(op[0]), .idle_op_in(op[1]),
    .global_irq_enable_op_in(op[2]), .global_irq_disable_op_in(op[3]),
    .watchdog_clear_op_in(op[4]), .green_sel_in(en[9]),
    .ext_pin_wake_enable_in(en[0]), .ext_pin_irq_enable_in(en[1]),
    .ext_irq_pins_evt_in(ev[0]), .timer_overflow_irq_enable_in(en[2]),
    .timer_counter_mode_in(en[3]), .timer_overflow_evt_in(ev[1]),
    .pin_change_wake_enable_in(en[4]), .pin_change_irq_enable_in(en[5]),
    .pin_change_evt_in(ev[2]), .serial_slave_wake_enable_in(en[6]),
    .serial_bus_irq_enable_in(en[7]), .serial_slave_mode_in(en[8]),
    .serial_rx_evt_in(ev[3]));
  wir_core_model i_wir_core_model (.core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in), .core_reset_in(core_reset_out),
    .resume_next_in(resume_next_out), .irq_vector_req_in(irq_vector_req_out),
    .vector_addr_in(vector_addr_out), .fetch_addr_out(pc));

  // ****************
  // tasks
  // ****************
  // x or z never counts as a match
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cyc();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic set_en(input logic [9:0] v);
    @(posedge core_clk_in);
    en <= v;
  endtask
  task automatic flg(input logic t, input logic p);
    chk({timeout_flag_out, power_down_flag_out}, {t, p});
  endtask
  // bounded wait for the hold to end
  task automatic wait_run();
    int k = 0;
    while (core_reset_out !== 1'b0 && k < 40) begin
      cyc();
      k++;
    end
    if (k == 40) begin
      failures++;
      finish_test();
    end
  endtask
  // one-cycle pulses; outputs looked at just after the taking edge
  task automatic do_op(input int i);
    @(posedge core_clk_in);
    op[i] <= 1'b1;
    @(posedge core_clk_in);
    op <= 5'h00;
    #1;
  endtask
  task automatic do_ev(input int i, input logic [2:0] e);
    @(posedge core_clk_in);
    ev[i] <= 1'b1;
    @(posedge core_clk_in);
    ev <= 4'h0;
    #1;
    chk({wake_out, resume_next_out, irq_vector_req_out}, e);
  endtask
  // kind 0 pin pulse, 1 watchdog time-out, 2 low voltage
  task automatic trig(input int k, input logic t, input logic p);
    @(posedge core_clk_in);
    reset_pin_n_in <= (k != 0);
    watchdog_timer_enable_in <= (k == 1);
    watchdog_timer_timeout_in <= (k == 1);
    low_voltage_reset_enable_in <= (k == 2);
    low_voltage_reset_in <= (k == 2);
    @(posedge core_clk_in);
    reset_pin_n_in <= 1'b1;
    watchdog_timer_enable_in <= 1'b0;
    watchdog_timer_timeout_in <= 1'b0;
    low_voltage_reset_in <= 1'b0;
    #1;
    chk(core_reset_out, 1'b1);
    flg(t, p);
    wait_run();
    chk({global_irq_enabled_out, mode_out, pc}, 19'h0_0000);
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (16) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    wait_run();
    flg(1'b1, 1'b1);
    do_ev(0, 3'b000);
    set_en(10'h002);
    do_ev(0, 3'b010);
    do_op(2);
    do_ev(0, 3'b001);
    chk(vector_addr_out, 16'h0006);
    cyc();
    chk(pc, 16'h0006);
    do_op(0);
    chk({mode_out, core_halt_out, watchdog_clear_out}, 4'hb);
    flg(1'b1, 1'b0);
    do_ev(0, 3'b000);
    set_en(10'h003);
    do_ev(0, 3'b101);
    chk({wake_src_out, timeout_flag_out, power_down_flag_out}, 6'h06);
    do_op(4);
    flg(1'b1, 1'b1);
    do_op(1);
    do_ev(0, 3'b110);
    // one wake source at a time, watchdog off, before each sleep
    set_en(10'h010);
    do_op(0);
    do_ev(2, 3'b110);
    do_ev(2, 3'b000);
    set_en(10'h020);
    do_op(0);
    do_ev(2, 3'b000);
    set_en(10'h030);
    do_ev(2, 3'b101);
    set_en(10'h140);
    do_op(0);
    do_ev(3, 3'b110);
    set_en(10'h180);
    do_ev(3, 3'b001);
    set_en(10'h380);
    do_ev(3, 3'b000);
    chk(serial_unusable_out, 1'b1);
    set_en(10'h00c);
    do_op(0);
    do_ev(1, 3'b101);
    set_en(10'h008);
    do_ev(1, 3'b000);
    do_op(3);
    set_en(10'h003);
    do_op(0);
    do_ev(0, 3'b110);
    do_op(4);
    trig(1, 1'b0, 1'b1);
    trig(0, 1'b0, 1'b1);
    do_op(0);
    trig(1, 1'b0, 1'b0);
    do_op(0);
    trig(0, 1'b1, 1'b0);
    trig(2, 1'b1, 1'b1);
    finish_test();
  end
endmodule

//--- verif/wir_asserts.sv
`timescale 1ns/10ps
module wir_asserts #(
  parameter int RST_HOLD_CYC = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // watched inputs
  input wire logic sleep_op_in,
  input wire logic ext_pin_wake_enable_in,
  input wire logic ext_pin_irq_enable_in,
  input wire logic ext_irq_pins_evt_in,
  input wire logic timer_overflow_evt_in,
  input wire logic pin_change_evt_in,
  input wire logic serial_rx_evt_in,
  input wire logic reset_pin_n_in,
  input wire logic watchdog_timer_enable_in,
  input wire logic watchdog_timer_timeout_in,
  input wire logic low_voltage_reset_enable_in,
  input wire logic low_voltage_reset_in,
  // watched outputs
  input wire logic core_reset_out,
  input wire logic core_halt_out,
  input wire logic [1:0] mode_out,
  input wire logic wake_out,
  input wire logic resume_next_out,
  input wire logic irq_vector_req_out,
  input wire logic [15:0] vector_addr_out,
  input wire logic global_irq_enabled_out,
  input wire logic timeout_flag_out,
  input wire logic power_down_flag_out
);
  // ****************
  // helpers
  // ****************
  logic run, wdt, low_voltage_reset, ev3;
  int hold_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  // lvr is masked out of watchdog checks since it takes flag priority
  assign run = !core_reset_out && !core_halt_out;
  assign wdt = watchdog_timer_enable_in && watchdog_timer_timeout_in;
  assign low_voltage_reset = low_voltage_reset_enable_in && low_voltage_reset_in;
  assign ev3 = timer_overflow_evt_in || pin_change_evt_in || serial_rx_evt_in;

  // quiet cycles spent in reset hold; any trigger restarts the count
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_cnt <= 0;
    end else if (!core_reset_out || !reset_pin_n_in || wdt || low_voltage_reset) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end

  // ****************
  // properties
  // ****************
  property p_vec_addr;
    irq_vector_req_out |-> vector_addr_out == 16'h0006;
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector address wrong");
  property p_vec_gie;
    irq_vector_req_out |-> $past(global_irq_enabled_out);
  endproperty
  a_vec_gie: assert property (p_vec_gie)
    else $error("vector taken with irqs off");
  property p_ext_off;
    ext_irq_pins_evt_in && !ext_pin_wake_enable_in && !ext_pin_irq_enable_in
      && !ev3 |=> !(wake_out || resume_next_out || irq_vector_req_out);
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("disabled pin had an effect");
  property p_sleep_in;
    sleep_op_in && run && reset_pin_n_in && !wdt && !low_voltage_reset |=>
      mode_out == 2'h2 && timeout_flag_out && !power_down_flag_out;
  endproperty
  a_sleep_in: assert property (p_sleep_in)
    else $error("sleep entry wrong");
  property p_only_sleep;
    core_halt_out && mode_out == 2'h2 && !$past(core_halt_out)
      |-> $past(sleep_op_in);
  endproperty
  a_only_sleep: assert property (p_only_sleep)
    else $error("sleep without sleep op");
  property p_wdt_rst;
    wdt && !low_voltage_reset |=> core_reset_out && !timeout_flag_out;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst)
    else $error("watchdog reset wrong");
  property p_wdt_slp;
    wdt && !low_voltage_reset && core_halt_out && mode_out == 2'h2 |=> !power_down_flag_out;
  endproperty
  a_wdt_slp: assert property (p_wdt_slp)
    else $error("watchdog sleep flags wrong");
  property p_pin_run;
    $fell(reset_pin_n_in) && run && !wdt && !low_voltage_reset |=> core_reset_out
      && $stable(timeout_flag_out) && $stable(power_down_flag_out);
  endproperty
  a_pin_run: assert property (p_pin_run)
    else $error("pin reset changed flags");
  property p_pin_slp;
    $fell(reset_pin_n_in) && core_halt_out && mode_out == 2'h2 && !wdt
      && !low_voltage_reset |=> timeout_flag_out && !power_down_flag_out;
  endproperty
  a_pin_slp: assert property (p_pin_slp)
    else $error("pin wake flags wrong");
  property p_hold;
    $fell(core_reset_out) |-> hold_cnt >= RST_HOLD_CYC - 1;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset hold too short");
  c_wake_vec: cover property (wake_out && irq_vector_req_out);
  c_wdt_sleep: cover property (wdt && core_halt_out);
  c_pin_run: cover property ($fell(reset_pin_n_in) && run);
endmodule

bind wir_wake_ctrl wir_asserts #(.RST_HOLD_CYC(RST_HOLD_CYC)) i_wir_asserts (.*);

//--- verif/wir_core_model.sv
`timescale 1ns/10ps
module wir_core_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // sequencing from the block
  input wire logic core_reset_in,
  input wire logic resume_next_in,
  input wire logic irq_vector_req_in,
  input wire logic [15:0] vector_addr_in,
  // where the core fetches next
  output logic [15:0] fetch_addr_out
);
  // ****************
  // program counter
  // ****************
  // a vector beats a plain resume, as the core would take it
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fetch_addr_out <= 16'h0000;
    end else if (core_reset_in) begin
      fetch_addr_out <= 16'h0000;
    end else if (irq_vector_req_in) begin
      fetch_addr_out <= vector_addr_in;
    end else if (resume_next_in) begin
      fetch_addr_out <= fetch_addr_out + 16'h0001;
    end
  end
endmodule
